// file: hdl/epc_eprom_protect_control.v
// wishbone slave modelling the one-time-programmable array and its control and option registers
// Functional notes
// - array of 6206 bytes, 256 secondary
// - protect never blocks secondary array programming
// - unprogrammed bytes read zero, bits only set
// - reset copies protect bit into control
// - no reset alters the options byte
// - control at 0x0007, fixed field layout
// - vectors live in top fourteen array bytes
// - latch mode captures address, four bytes
// - program enable rules, cleared with latch
// - array unreadable while latching, protect copy readable
`timescale 1ns/1ns
`include "epc_consts.vh"

module epc_eprom_protect_control (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [14:0] adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // core status
  input  wire        stop_i,
  // pins
  input  wire        bootloader_mode_i,
  input  wire        vpp_high_i,
  // option and control outputs
  output reg         program_enable_o,
  output reg         program_latch_enable_o,
  output reg         external_clock_option_o,
  output reg         reset_delay_select_o,
  output reg         watchdog_after_reset_o,
  output reg         watchdog_in_wait_o,
  output reg         second_port_pulldown_o,
  output reg         third_port_pulldown_o
);

  // ==========================================================
  // storage
  reg [7:0]  mem_r [0:`EPC_ARRAY_BYTES-1];
  reg [7:0]  options_r;
  reg        ptc_r;
  reg        lat_r;
  reg        pgm_r;
  reg        external_clock_option_r;
  reg [10:0] grp_r;
  reg [7:0]  lbuf_r [0:`EPC_LATCH_BYTES-1];
  reg [3:0]  lmask_r;
  reg        done_r;
  reg [1:0]  boot_s_r;
  reg [1:0]  vpp_s_r;
  integer    k;
  integer    j;

  // erased state of the one-time array and options byte
  initial begin
    for (k = 0; k < `EPC_ARRAY_BYTES; k = k + 1)
      mem_r[k] = `EPC_ERASED;
    options_r = `EPC_OPT_INIT;
  end

  // ==========================================================
  // address decode
  function in_sec;
    input [12:0] a;
    in_sec = (a >= `EPC_SEC_BASE) && (a <= `EPC_SEC_LAST);
  endfunction

  function in_main;
    input [12:0] a;
    // options byte sits inside the window but is its own register
    in_main = (a >= `EPC_MAIN_BASE) && (a <= `EPC_MAIN_LAST) && (a != `EPC_IDX_OPTIONS);
  endfunction

  function [12:0] arr_idx;
    input [12:0] a;
    if (a <= `EPC_SEC_LAST)
      arr_idx = a - `EPC_SEC_BASE;
    else
      arr_idx = a - `EPC_MAIN_BASE + 13'h0100;
  endfunction

  function at_ctrl;
    input [12:0] a;
    at_ctrl = (a == `EPC_IDX_CTRL);
  endfunction

  function at_opt;
    input [12:0] a;
    at_opt = (a == `EPC_IDX_OPTIONS);
  endfunction

  wire [12:0] idx      = adr_i[14:2];
  wire        req      = cyc_i & stb_i & ~ack_o;
  wire        wr       = req & we_i & sel_i[0];
  wire        rd       = req & ~we_i;
  wire        is_arr   = in_sec(idx) | in_main(idx);
  wire        prot     = options_r[`EPC_OPT_PROT];
  wire        boot_m   = boot_s_r[1];
  wire        vpp_ok   = vpp_s_r[1];
  wire [7:0]  wd       = dat_i[7:0];
  // protect blocks the main array only
  wire        can_prog = in_sec(idx) | (in_main(idx) & ~prot);
  wire        lat_wr   = wr & is_arr & lat_r & ~pgm_r & can_prog;
  wire        grp_ok   = (lmask_r == 4'h0) | (idx[12:2] == grp_r);

  // ==========================================================
  // pin synchronisers
  always @(posedge clk_i) begin
    if (rst_i) begin
      boot_s_r <= 2'h0;
      vpp_s_r  <= 2'h0;
    end else begin
      boot_s_r <= {boot_s_r[0], bootloader_mode_i};
      vpp_s_r  <= {vpp_s_r[0], vpp_high_i};
    end
  end

  // ==========================================================
  // control register
  always @(posedge clk_i) begin
    if (rst_i) begin
      ptc_r  <= options_r[`EPC_OPT_PROT];
      lat_r  <= 1'b0;
      pgm_r  <= 1'b0;
      external_clock_option_r <= 1'b0;
    end else if (stop_i) begin
      lat_r <= 1'b0;
      pgm_r <= 1'b0;
    end else if (wr && at_ctrl(idx)) begin
      external_clock_option_r <= wd[`EPC_CTRL_EXTERNAL_CLOCK_OPTION];
      lat_r  <= wd[`EPC_CTRL_LAT];
      // set only with a byte latched, never cleared directly
      pgm_r  <= wd[`EPC_CTRL_LAT] &
                (pgm_r | (lat_r & wd[`EPC_CTRL_PGM] & (lmask_r != 4'h0)));
    end
  end

  // ==========================================================
  // programming latches and commit
  always @(posedge clk_i) begin
    if (rst_i || !lat_r) begin
      lmask_r <= 4'h0;
      grp_r   <= 11'h000;
      done_r  <= 1'b0;
    end else begin
      // bytes outside the first byte's group of four are ignored
      if (lat_wr && grp_ok) begin
        grp_r                <= idx[12:2];
        lmask_r[idx[1:0]]    <= 1'b1;
        lbuf_r[idx[1:0]]     <= wd;
      end
      // commit once per latch session, only with the supply present
      if (pgm_r && vpp_ok && !done_r) begin
        done_r <= 1'b1;
        for (j = 0; j < `EPC_LATCH_BYTES; j = j + 1)
          if (lmask_r[j])
            mem_r[arr_idx({grp_r, j[1:0]})] <=
              mem_r[arr_idx({grp_r, j[1:0]})] | lbuf_r[j];
      end
    end
  end

  // ==========================================================
  // nonvolatile options byte, untouched by reset
  always @(posedge clk_i) begin
    if (wr && boot_m && at_opt(idx))
      options_r <= options_r | (wd & `EPC_OPT_MASK);
  end

  // ==========================================================
  // wishbone answer
  // one-cycle ack, dropped while the master still holds the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      if (rd) begin
        if (at_ctrl(idx))
          dat_o <= {24'h000000, 1'b0, ptc_r, lat_r, pgm_r, external_clock_option_r, 3'h0};
        else if (at_opt(idx))
          dat_o <= {24'h000000, options_r & `EPC_OPT_MASK};
        else if (is_arr && !lat_r)
          dat_o <= {24'h000000, mem_r[arr_idx(idx)]};
        else
          dat_o <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // registered outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      program_enable_o        <= 1'b0;
      program_latch_enable_o  <= 1'b0;
      external_clock_option_o <= 1'b0;
    end else begin
      program_enable_o        <= pgm_r;
      program_latch_enable_o  <= lat_r;
      external_clock_option_o <= external_clock_option_r;
    end
  end

  // ==========================================================
  // option copies, no reset so they always follow the options byte
  always @(posedge clk_i) begin
    reset_delay_select_o   <= options_r[`EPC_OPT_RESET_DELAY_SELECT];
    watchdog_after_reset_o <= options_r[`EPC_OPT_WATCHDOG_AFTER_RESET];
    watchdog_in_wait_o     <= options_r[`EPC_OPT_WATCHDOG_IN_WAIT];
    second_port_pulldown_o <= options_r[`EPC_OPT_SECOND_PORT_PULLDOWN];
    third_port_pulldown_o  <= options_r[`EPC_OPT_THIRD_PORT_PULLDOWN];
  end

endmodule // epc_eprom_protect_control

// file: include/epc_consts.vh
// constants of the program memory protect and control block
`ifndef EPC_CONSTS_VH
`define EPC_CONSTS_VH
// register indexes (byte address = 4 * index)
`define EPC_IDX_CTRL      13'h0007
`define EPC_IDX_OPTIONS   13'h1efe
// secondary array window
`define EPC_SEC_BASE      13'h0100
`define EPC_SEC_LAST      13'h01ff
// main array window, vectors included
`define EPC_MAIN_BASE     13'h08c2
`define EPC_MAIN_LAST     13'h1fff
`define EPC_VEC_BASE      13'h1ff2
// sizes
`define EPC_ARRAY_BYTES   6206
`define EPC_SEC_BYTES     256
`define EPC_LATCH_BYTES   4
// erased byte value
`define EPC_ERASED        8'h00
// control register fields
`define EPC_CTRL_PTC      6
`define EPC_CTRL_LAT      5
`define EPC_CTRL_PGM      4
`define EPC_CTRL_EXTERNAL_CLOCK_OPTION     3
// options register fields
`define EPC_OPT_PROT      6
`define EPC_OPT_RESET_DELAY_SELECT      4
`define EPC_OPT_WATCHDOG_AFTER_RESET      3
`define EPC_OPT_WATCHDOG_IN_WAIT      2
`define EPC_OPT_SECOND_PORT_PULLDOWN      1
`define EPC_OPT_THIRD_PORT_PULLDOWN      0
`define EPC_OPT_MASK      8'h5f
`define EPC_OPT_INIT      8'h00
// reset values
`define EPC_CTRL_RST      8'h00
`endif

// file: testbench/epc_eprom_protect_control_properties.sv
// port checker for the program memory protect and control block
`timescale 1ns/1ns
module epc_chk (
  // bus and core
  input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, stop_i,
  input wire logic [31:0] dat_o,
  // control and option copies
  input wire logic        program_enable_o, program_latch_enable_o, external_clock_option_o,
  input wire logic        reset_delay_select_o, watchdog_after_reset_o, watchdog_in_wait_o,
  input wire logic        second_port_pulldown_o, third_port_pulldown_o
);
  // ==========
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("long ack");
  rd_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper data");
  stop_clear_a: assert property (stop_i |-> ##2 !program_latch_enable_o)
    else $error("stop kept latch");
  pgm_needs_lat_a: assert property (program_enable_o |-> program_latch_enable_o)
    else $error("pgm alone");
  pgm_drop_a: assert property ($fell(program_latch_enable_o) |-> !program_enable_o)
    else $error("pgm kept");
  rst_ctrl_a: assert property ($fell(rst_i) |-> !program_latch_enable_o &&
    !program_enable_o && !external_clock_option_o)
    else $error("ctrl not cleared");
  opt_hold_a: assert property ($changed({reset_delay_select_o,
    watchdog_after_reset_o, watchdog_in_wait_o, second_port_pulldown_o,
    third_port_pulldown_o}) |-> $past(cyc_i && stb_i && we_i, 2))
    else $error("options moved");
endmodule // epc_chk
bind epc_eprom_protect_control epc_chk u_chk (.*);

// file: testbench/tb_top.sv
// self-checking bench for the program memory protect and control block
`timescale 1ns/1ns
`include "epc_consts.vh"
module tb_top;
  // ==========
  // signals
  reg         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, stop_i = 0;
  reg         bootloader_mode_i = 0, vpp_high_i = 1;
  reg  [14:0] adr_i = 0;
  reg  [3:0]  sel_i = 0;
  reg  [31:0] dat_i = 0;
  wire [31:0] dat_o;
  wire        ack_o, program_enable_o, program_latch_enable_o, external_clock_option_o;
  wire        reset_delay_select_o, watchdog_after_reset_o, watchdog_in_wait_o;
  wire        second_port_pulldown_o, third_port_pulldown_o;
  integer     fails = 0, n_tests = 0, tmo = 0, seed = 32'hfd7ef3b6, i;
  reg  [7:0]  rd, opt, v, mem [0:8191];
  reg         p;
  epc_eprom_protect_control DUT (.*);
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (++tmo > 4000) begin
    fails++;
    wrap_up;
  end
  // ==========
  // tasks
  task wrap_up;
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input [7:0] s, input [7:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wb(input w, input [12:0] a, input [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; sel_i <= 4'h1;
    adr_i <= {a, 2'b00}; dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o[7:0];
    cyc_i <= 0; stb_i <= 0;
  endtask
  task rchk(input [12:0] a, input [7:0] e);
    wb(0, a, 8'h00);
    chk(rd, e);
  endtask
  task rst;
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    p = opt[6];
  endtask
  // latch k bytes from a, raise program enable, then clear and read back
  task prog(input [12:0] a, input integer k);
    integer j;
    reg     lb;
    lb = (k > 0) && (!opt[6] || a < `EPC_MAIN_BASE);
    wb(1, `EPC_IDX_CTRL, 8'h20);
    rchk(a, 8'h00);
    for (j = 0; j < k; j++) begin
      v = $random(seed);
      wb(1, a + j[12:0], v);
      if (lb && vpp_high_i) mem[a+j] = mem[a+j] | v;
    end
    wb(1, `EPC_IDX_CTRL, 8'h30);
    wb(1, `EPC_IDX_CTRL, 8'h20);
    rchk(`EPC_IDX_CTRL, {1'b0, p, 1'b1, lb, 4'h0});
    chk({7'h0, program_enable_o}, {7'h0, lb});
    wb(1, `EPC_IDX_CTRL, 8'h00);
    for (j = 0; j < k; j++) rchk(a + j[12:0], mem[a+j]);
  endtask
  // ==========
  // sequence
  initial begin
    for (i = 0; i < 8192; i++) mem[i] = 0;
    opt = 0;
    rst;
    rchk(`EPC_IDX_CTRL, 8'h00);
    rchk(`EPC_IDX_OPTIONS, 8'h00);
    rchk(`EPC_VEC_BASE, `EPC_ERASED);
    rchk(13'h0020, 8'h00);
    wb(1, `EPC_IDX_OPTIONS, 8'h5f);
    rchk(`EPC_IDX_OPTIONS, 8'h00);
    prog(`EPC_VEC_BASE + 13'h2, 4);
    prog(`EPC_VEC_BASE + 13'h2, 4);
    prog(`EPC_MAIN_BASE + 13'h2, 0);
    vpp_high_i <= 0;
    repeat (3) @(posedge clk_i);
    prog(`EPC_MAIN_BASE + 13'h6, 2);
    vpp_high_i <= 1;
    repeat (3) @(posedge clk_i);
    wb(1, `EPC_IDX_CTRL, 8'h28);
    rchk(`EPC_IDX_CTRL, {1'b0, p, 6'h28});
    chk({5'h0, program_enable_o, program_latch_enable_o,
      external_clock_option_o}, 8'h03);
    stop_i <= 1;
    @(posedge clk_i) stop_i <= 0;
    rchk(`EPC_IDX_CTRL, {1'b0, p, 6'h08});
    chk({5'h0, program_enable_o, program_latch_enable_o,
      external_clock_option_o}, 8'h01);
    bootloader_mode_i <= 1;
    repeat (3) @(posedge clk_i);
    v = $random(seed);
    v = (v & 8'h5f) | 8'h40;
    wb(1, `EPC_IDX_OPTIONS, v);
    opt = opt | v;
    rchk(`EPC_IDX_OPTIONS, opt);
    chk({3'h0, reset_delay_select_o, watchdog_after_reset_o, watchdog_in_wait_o,
      second_port_pulldown_o, third_port_pulldown_o}, opt & 8'h1f);
    rst;
    rchk(`EPC_IDX_CTRL, 8'h40);
    rchk(`EPC_IDX_OPTIONS, opt);
    prog(`EPC_SEC_LAST - 13'h3, 4);
    prog(`EPC_VEC_BASE + 13'h6, 4);
    wrap_up;
  end
endmodule // tb_top
